// file: rtl/vout_ovuv_fault_response.sv
// one channel of output over/under-voltage fault response
`timescale 1ns/10ps
`default_nettype none
module vout_ovuv_fault_response #(
  parameter int RESTART_INTERVAL = vout_fault_pkg::RESTART_CYCLES
) (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst,
  // reaction settings, written by the management interface
  input  wire logic [7:0]  over_voltage_reaction,
  input  wire logic [7:0]  under_voltage_reaction,
  // thresholds and sampled output voltage
  input  wire logic [15:0] over_voltage_threshold,
  input  wire logic [15:0] under_voltage_threshold,
  input  wire logic [15:0] voutSample,
  input  wire logic        sampleValid,
  // channel control
  input  wire logic        channelOn,
  input  wire logic        oddCurrentMode,
  input  wire logic        biasLost,
  input  wire logic        otherFaultOff,
  input  wire logic        clearFaults,
  // status and outputs
  output logic             statusByteVout,
  output logic             statusWordVout,
  output logic             statusVoutOv,
  output logic             statusVoutUv,
  output logic             channelEnable,
  output logic             host_alert_line_n_o,
  output logic             host_alert_line_n_oe
);
  typedef enum {ST_OFF, ST_RUN, ST_DEGLITCH, ST_SHUT, ST_WAIT} state_t;
  typedef struct packed {
    state_t      state;
    logic [8:0]  tick;
    logic [2:0]  samples;
    logic [31:0] restart;
    logic [2:0]  ovRetry;
    logic [2:0]  uvRetry;
    logic        ovFlag;
    logic        uvFlag;
    logic        lastOv;
    logic        enable;
    logic        syncOn1;
    logic        syncOn2;
  } regs_t;
  regs_t r;
  regs_t next_r;
  logic  ovNow;
  logic  uvNow;
  logic  sampleTick;
  logic  faultNow;
  logic  syncOn2;
  logic  keepOn;
  logic [7:0] react;
  logic [2:0] retryUsed;

  // reaction setting fields
  function automatic logic [1:0] action_of(input logic [7:0] setting);
    return setting[vout_fault_pkg::ACTION_HI:vout_fault_pkg::ACTION_LO];
  endfunction : action_of

  function automatic logic [2:0] retry_of(input logic [7:0] setting);
    return setting[vout_fault_pkg::RETRY_HI:vout_fault_pkg::RETRY_LO];
  endfunction : retry_of

  function automatic logic [2:0] delay_of(input logic [7:0] setting);
    return setting[vout_fault_pkg::DELAY_HI:vout_fault_pkg::DELAY_LO];
  endfunction : delay_of

  // compare against 16-bit limits; odd current channels never fault
  assign ovNow = sampleValid && !oddCurrentMode
               && (voutSample > over_voltage_threshold);
  assign uvNow = sampleValid && !oddCurrentMode
               && (voutSample < under_voltage_threshold);
  assign faultNow = ovNow || uvNow;
  assign syncOn2 = r.syncOn2;
  assign keepOn = syncOn2 && !biasLost && !otherFaultOff;
  assign sampleTick = (r.tick == vout_fault_pkg::SAMPLE_LAST);
  assign react = ovNow ? over_voltage_reaction : under_voltage_reaction;
  assign retryUsed = r.lastOv ? r.ovRetry : r.uvRetry;

  always_comb
  begin
    next_r = r;
    next_r.tick = sampleTick ? 9'h000 : r.tick + 9'h001;
    // channel-on pin through two flops
    next_r.syncOn1 = channelOn;
    next_r.syncOn2 = r.syncOn1;
    // flags: set wins over clear
    if (clearFaults)
    begin
      next_r.ovFlag = 1'b0;
      next_r.uvFlag = 1'b0;
    end
    if (ovNow)
      next_r.ovFlag = 1'b1;
    if (uvNow)
      next_r.uvFlag = 1'b1;
    case (r.state)
      ST_OFF:
      begin
        next_r.enable = 1'b0;
        // retry setting latched at each switch-on
        next_r.ovRetry = retry_of(over_voltage_reaction);
        next_r.uvRetry = retry_of(under_voltage_reaction);
        if (syncOn2)
        begin
          next_r.enable = 1'b1;
          next_r.state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (faultNow)
        begin
          next_r.lastOv = ovNow;
          if (react[vout_fault_pkg::ACTION_HI])
            next_r.state = ST_SHUT;
          else if (action_of(react) == vout_fault_pkg::ACT_DEGLITCH)
          begin
            next_r.samples = delay_of(react);
            if (delay_of(react) == vout_fault_pkg::DELAY_NONE)
              next_r.state = ST_SHUT;
            else
            begin
              next_r.tick = 9'h000;
              next_r.state = ST_DEGLITCH;
            end
          end
          // action 00b: keep running
        end
      end
      ST_DEGLITCH:
      begin
        if (sampleValid && !faultNow)
          next_r.state = ST_RUN;
        else if (sampleTick)
        begin
          next_r.samples = r.samples - 3'h1;
          if (r.samples == 3'h1)
            next_r.state = ST_SHUT;
        end
      end
      ST_SHUT:
      begin
        next_r.enable = 1'b0;
        next_r.restart = 32'h0;
        next_r.state = ST_WAIT;
      end
      ST_WAIT:
      begin
        next_r.enable = 1'b0;
        next_r.restart = r.restart + 32'h1;
        if (retryUsed == vout_fault_pkg::RETRY_NONE)
        begin
          if (clearFaults)
            next_r.state = ST_OFF;
        end
        else if (r.restart >= 32'(RESTART_INTERVAL - 1))
        begin
          next_r.enable = 1'b1;
          next_r.state = ST_RUN;
        end
      end
      default:
        next_r.state = ST_OFF;
    endcase
    // commanded off, bias loss or another fault drop enable and return to ST_OFF; flags keep their value
    if (!syncOn2 || biasLost || otherFaultOff)
    begin
      next_r.enable = 1'b0;
      next_r.state = ST_OFF;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (rst)
    begin
      r.state <= ST_OFF;
      r.tick <= 9'h000;
      r.samples <= 3'h0;
      r.restart <= 32'h0;
      r.ovRetry <= vout_fault_pkg::RETRY_NONE;
      r.uvRetry <= vout_fault_pkg::RETRY_NONE;
      r.ovFlag <= 1'b0;
      r.uvFlag <= 1'b0;
      r.lastOv <= 1'b0;
      r.enable <= 1'b0;
      r.syncOn1 <= 1'b0;
      r.syncOn2 <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign statusVoutOv = r.ovFlag;
  assign statusVoutUv = r.uvFlag;
  assign statusByteVout = r.ovFlag || r.uvFlag;
  assign statusWordVout = r.ovFlag || r.uvFlag;
  assign channelEnable = r.enable;
  // open drain: drive low while any flag stands
  assign host_alert_line_n_o = 1'b0;
  assign host_alert_line_n_oe = r.ovFlag || r.uvFlag;

  // flags and alert
  alert_follows_a: assert property (@(posedge clk_sys) disable iff (rst)
    (ovNow || uvNow) |=> host_alert_line_n_oe)
    else $error("alert not driven after fault");

  flag_set_a: assert property (@(posedge clk_sys) disable iff (rst)
    ovNow |=> statusVoutOv && statusByteVout && statusWordVout)
    else $error("OV flags not set");

  uv_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    uvNow |=> statusVoutUv && statusByteVout && statusWordVout)
    else $error("UV flags not set");

  flag_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (statusVoutOv && !clearFaults) |=> statusVoutOv)
    else $error("OV flag dropped without clear");

  flag_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (clearFaults && !ovNow && !uvNow) |=> !statusByteVout && !host_alert_line_n_oe)
    else $error("flags survive clear");

  odd_ignore_a: assert property (@(posedge clk_sys) disable iff (rst)
    (oddCurrentMode && !r.ovFlag && !r.uvFlag && !clearFaults) |=> !r.ovFlag)
    else $error("current channel flagged OV");

  odd_uv_a: assert property (@(posedge clk_sys) disable iff (rst)
    (oddCurrentMode && !r.uvFlag) |=> !r.uvFlag)
    else $error("current channel flagged UV");

  // fault actions
  ignore_run_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_RUN && faultNow && keepOn
     && action_of(react) == vout_fault_pkg::ACT_IGNORE) |=> channelEnable)
    else $error("ignore action dropped enable");

  shut_now_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_RUN && faultNow && react[vout_fault_pkg::ACTION_HI]) |=> ##1 !channelEnable)
    else $error("immediate shutdown missing");

  degl_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_RUN && faultNow && action_of(react) == vout_fault_pkg::ACT_DEGLITCH
     && delay_of(react) == vout_fault_pkg::DELAY_NONE) |=> ##1 !channelEnable)
    else $error("zero delay did not shut down");

  degl_enter_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_RUN && faultNow && keepOn && action_of(react) == vout_fault_pkg::ACT_DEGLITCH
     && delay_of(react) != vout_fault_pkg::DELAY_NONE) |=> r.state == ST_DEGLITCH && channelEnable)
    else $error("deglitch not started");

  deglitch_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_DEGLITCH && keepOn)
    |=> channelEnable)
    else $error("shutdown during deglitch");

  degl_end_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_DEGLITCH && sampleTick && r.samples == 3'h1 && !(sampleValid && !faultNow))
    |=> ##1 !channelEnable)
    else $error("no shutdown after deglitch");

  degl_abort_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_DEGLITCH && sampleValid && !faultNow && keepOn)
    |=> r.state == ST_RUN && channelEnable)
    else $error("cleared fault still deglitched");

  // restart, release and forced off
  no_retry_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_WAIT && retryUsed == vout_fault_pkg::RETRY_NONE && !clearFaults)
    |=> !channelEnable)
    else $error("restart without retry");

  retry_wait_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_WAIT && r.restart < 32'(RESTART_INTERVAL - 1)) |=> !channelEnable)
    else $error("restart before interval");

  retry_restart_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_WAIT && retryUsed != vout_fault_pkg::RETRY_NONE && keepOn
     && r.restart >= 32'(RESTART_INTERVAL - 1)) |=> channelEnable)
    else $error("restart missing");

  retry_latch_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state != ST_OFF) |=> $stable(r.ovRetry) && $stable(r.uvRetry))
    else $error("retry setting changed while on");

  latch_release_a: assert property (@(posedge clk_sys) disable iff (rst)
    (r.state == ST_WAIT && retryUsed == vout_fault_pkg::RETRY_NONE && clearFaults)
    |=> r.state == ST_OFF && !channelEnable)
    else $error("clear did not release latch");

  cmd_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!syncOn2 || biasLost) |=> !channelEnable)
    else $error("enable held while off");

  other_off_a: assert property (@(posedge clk_sys) disable iff (rst)
    (otherFaultOff || biasLost) |=> !channelEnable && r.state == ST_OFF)
    else $error("forced off ignored");
endmodule : vout_ovuv_fault_response
`default_nettype wire

// file: rtl/vout_fault_pkg.sv
// constants for the output over/under-voltage fault response block
package vout_fault_pkg;
  localparam int CLK_MHZ = 40;
  // supervisor sample period in ns (12.2 us typical)
  localparam int SAMPLE_PERIOD_NS = 12200;
  localparam int SAMPLE_CYCLES = (SAMPLE_PERIOD_NS * CLK_MHZ) / 1000;
  localparam logic [8:0] SAMPLE_LAST = 9'(SAMPLE_CYCLES - 1);
  // reaction register fields
  localparam int ACTION_HI = 7;
  localparam int ACTION_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [1:0] ACT_IGNORE = 2'h0;
  localparam logic [1:0] ACT_DEGLITCH = 2'h1;
  localparam logic [2:0] RETRY_NONE = 3'h0;
  localparam logic [2:0] DELAY_NONE = 3'h0;
  localparam logic [7:0] REACTION_RESET = 8'h00;
  // status bit positions
  localparam int SB_VOUT_BIT = 5;
  localparam int SW_VOUT_BIT = 15;
  localparam int SV_OV_BIT = 7;
  localparam int SV_UV_BIT = 4;
  // restart interval default, in cycles
  localparam int RESTART_CYCLES = 8000;
endpackage : vout_fault_pkg

// file: tb/conv_model.sv
// converter and alert pull-up model for the fault bench
`timescale 1ns/10ps
`default_nettype none
module conv_model (
  // clock
  input  wire logic        clk_sys,
  // converter side
  input  wire logic        channelEnable,
  input  wire logic [15:0] level,
  output logic [15:0]      voutSample,
  output logic             sampleValid,
  // alert wire
  input  wire logic        alertO,
  input  wire logic        alertOe,
  output logic             alertN
);
  logic [1:0] phase = 2'h0;
  // one supervisor result every fourth cycle, 0 V while disabled
  always_ff @(posedge clk_sys)
  begin
    phase       <= phase + 2'h1;
    sampleValid <= (phase == 2'h3);
    voutSample  <= channelEnable ? level : 16'h0000;
  end
  // released line is pulled up
  assign alertN = alertOe ? alertO : 1'b1;
endmodule : conv_model
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the fault response block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, sampleValid, channelOn = 1'b0, odd = 1'b0;
  logic clearFaults = 1'b0, sbV, swV, ovF, uvF, channelEnable, aO, aOe, alertN;
  logic [7:0] ovR = 8'h00, uvR = 8'h00;
  logic [15:0] uvThr = 16'h0000, level = 16'h4000, voutSample;
  logic biasLost = 1'b0, otherOff = 1'b0;
  int fails = 0, samplesChecked = 0, cycles = 0;
  vout_ovuv_fault_response #(.RESTART_INTERVAL(20)) uut (.clk_sys(clk_sys), .rst(rst),
    .over_voltage_reaction(ovR), .under_voltage_reaction(uvR),
    .over_voltage_threshold(16'h8000), .under_voltage_threshold(uvThr),
    .voutSample(voutSample), .sampleValid(sampleValid), .channelOn(channelOn),
    .oddCurrentMode(odd), .biasLost(biasLost), .otherFaultOff(otherOff),
    .clearFaults(clearFaults), .statusByteVout(sbV), .statusWordVout(swV),
    .statusVoutOv(ovF), .statusVoutUv(uvF), .channelEnable(channelEnable),
    .host_alert_line_n_o(aO), .host_alert_line_n_oe(aOe));
  conv_model partner (.clk_sys(clk_sys), .channelEnable(channelEnable), .level(level),
    .voutSample(voutSample), .sampleValid(sampleValid), .alertO(aO), .alertOe(aOe),
    .alertN(alertN));
  always #12.5 clk_sys = ~clk_sys;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      fails++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samplesChecked++;
    if (seen !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask : cyc
  task automatic wait_en(input logic e, input int lim);
    int n;
    n = 0;
    while (channelEnable !== e && n < lim)
    begin
      cyc(1);
      n++;
    end
    check(channelEnable, e);
  endtask : wait_en
  // off, clear, on again with fresh settings and a healthy output
  task automatic start(input logic [7:0] ov, input logic [7:0] uv);
    ovR = ov;
    uvR = uv;
    level = 16'h4000;
    channelOn = 1'b0;
    clearFaults = 1'b1;
    cyc(4);
    clearFaults = 1'b0;
    channelOn = 1'b1;
    wait_en(1'b1, 10);
    check({ovF, uvF, alertN}, 3'h1);
  endtask : start
  task automatic s_ignore;
    start(8'h00, 8'h00);
    level = 16'h9000;
    cyc(12);
    check({ovF, sbV, swV}, 3'h7);
    check(alertN, 1'b0);
    check(channelEnable, 1'b1);
  endtask : s_ignore
  task automatic s_latch;
    start(8'h80, 8'h00);
    level = 16'h9000;
    cyc(12);
    check(channelEnable, 1'b0);
    level = 16'h4000;
    cyc(40);
    check(channelEnable, 1'b0);
    clearFaults = 1'b1;
    cyc(1);
    clearFaults = 1'b0;
    wait_en(1'b1, 10);
  endtask : s_latch
  task automatic s_odd;
    odd = 1'b1;
    start(8'h80, 8'h80);
    level = 16'h9000;
    cyc(12);
    check({ovF, alertN, channelEnable}, 3'h3);
    level = 16'h4000;
    cyc(1);
    odd = 1'b0;
  endtask : s_odd
  task automatic s_retry;
    start(8'h88, 8'h00);
    ovR = 8'h80;
    level = 16'h9000;
    cyc(12);
    check(channelEnable, 1'b0);
    level = 16'h4000;
    wait_en(1'b1, 40);
    level = 16'h9000;
    cyc(12);
    check(channelEnable, 1'b0);
    biasLost = 1'b1;
    level = 16'h4000;
    cyc(40);
    check(channelEnable, 1'b0);
    biasLost = 1'b0;
    wait_en(1'b1, 10);
    otherOff = 1'b1;
    cyc(2);
    check(channelEnable, 1'b0);
    otherOff = 1'b0;
    wait_en(1'b1, 10);
  endtask : s_retry
  task automatic s_deglitch;
    start(8'h00, 8'h41);
    uvThr = 16'h1000;
    level = 16'h0800;
    cyc(100);
    level = 16'h4000;
    cyc(600);
    check({uvF, channelEnable}, 2'h3);
    level = 16'h0800;
    cyc(300);
    check({uvF, channelEnable}, 2'h3);
    wait_en(1'b0, 400);
    uvThr = 16'h0000;
    start(8'h40, 8'h00);
    level = 16'h9000;
    cyc(12);
    check(channelEnable, 1'b0);
  endtask : s_deglitch
  initial
  begin
    cyc(4);
    rst = 1'b0;
    check({ovF, uvF, channelEnable, aOe}, 4'h0);
    s_ignore();
    s_latch();
    s_odd();
    s_retry();
    s_deglitch();
    tally_and_finish();
  end
endmodule : tb_top
`default_nettype wire
